// ==== verilog/iifm_pkg.sv ====
package iifm_pkg;

  // ----------------------------------------------------------------
  // Widths and buffer shape
  // ----------------------------------------------------------------
  localparam int SMP_W   = 14;
  localparam int INT_W   = 16;
  localparam int FIFO_W  = 2 * SMP_W;
  localparam int FIFO_D  = 32;
  localparam int FIFO_AW = 5;

  // ----------------------------------------------------------------
  // Register map: index times four is the byte address
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL1_IDX = 8'h01;
  localparam logic [7:0] CTRL2_IDX = 8'h02;
  localparam logic [7:0] STAT_IDX  = 8'h03;
  localparam logic [7:0] CTRL1_ADR = CTRL1_IDX << 2;
  localparam logic [7:0] CTRL2_ADR = CTRL2_IDX << 2;
  localparam logic [7:0] STAT_ADR  = STAT_IDX << 2;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int INTERP_LSB  = 0;
  localparam int REAL_BIT    = 2;
  localparam int SIDE_BIT    = 3;
  localparam int MOD_LSB     = 4;
  localparam int RUN_BIT     = 0;
  localparam int FMT_BIT     = 7;
  localparam int STAT_LVL_LSB = 0;
  localparam int STAT_UND_BIT = 8;
  localparam int STAT_RUN_BIT = 9;
  localparam logic [7:0] CTRL1_RST = 8'h00;
  localparam logic [7:0] CTRL2_RST = 8'h00;

  // Modulation field codes
  localparam logic [1:0] MOD_OFF = 2'h0;
  localparam logic [1:0] MOD_FS2 = 2'h1;
  localparam logic [1:0] MOD_FS4 = 2'h2;
  localparam logic [1:0] MOD_FS8 = 2'h3;

  // ----------------------------------------------------------------
  // Shared arithmetic
  // ----------------------------------------------------------------
  function automatic logic signed [13:0] sat14(input logic signed [19:0] v);
    if (v > 20'sh01fff) return 14'sh1fff;
    if (v < 20'shfe000) return 14'sh2000;
    return v[13:0];
  endfunction : sat14

  function automatic logic signed [15:0] sat16(input logic signed [21:0] v);
    if (v > 22'sh007fff) return 16'sh7fff;
    if (v < 22'sh3f8000) return 16'sh8000;
    return v[15:0];
  endfunction : sat16

  // Carrier in Q1.14, phase in eighths of a turn
  function automatic logic signed [15:0] cos_q14(input logic [2:0] ph);
    case (ph)
      3'h0:    return 16'sh4000;
      3'h1:    return 16'sh2d41;
      3'h3:    return 16'shd2bf;
      3'h4:    return 16'shc000;
      3'h5:    return 16'shd2bf;
      3'h7:    return 16'sh2d41;
      default: return 16'sh0000;
    endcase
  endfunction : cos_q14

  // Offset binary input flips its top bit to become two's complement
  function automatic logic signed [15:0] to_int(input logic [13:0] w, input logic ofs);
    logic [13:0] t;
    t = ofs ? {~w[13], w[12:0]} : w;
    return {{2{t[13]}}, t};
  endfunction : to_int

endpackage : iifm_pkg

// ==== verilog/iifm_stream_if.sv ====
`timescale 1ns/1ps
interface iifm_stream_if #(parameter int W = 28);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : iifm_stream_if

// ==== verilog/iifm_fifo.sv ====
`timescale 1ns/1ps
module iifm_fifo #(
  parameter int W     = iifm_pkg::FIFO_W,
  parameter int DEPTH = iifm_pkg::FIFO_D,
  parameter int AW    = iifm_pkg::FIFO_AW
) (
  input  wire logic  clk,
  input  wire logic  rst_n,
  iifm_stream_if.snk wr,
  iifm_stream_if.src rd,
  output logic [AW:0] level
);
  logic [W-1:0] mem_q [DEPTH];
  logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
  logic [AW:0]   cnt_q, cnt_d;
  logic          rdy_q, rdy_d, vld_q, vld_d;
  logic [W-1:0]  dat_q, dat_d;
  logic          push, pop;

  // ----------------------------------------------------------------
  // Pointers and flags, all registered so both sides see flops
  // ----------------------------------------------------------------
  assign push = wr.valid && rdy_q;
  assign pop  = rd.ready && vld_q;

  // Head word is read ahead; a push into the head slot bypasses memory
  always_comb begin
    wp_d  = wp_q + AW'(push);
    rp_d  = rp_q + AW'(pop);
    cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    rdy_d = cnt_d != (AW+1)'(DEPTH);
    vld_d = cnt_d != '0;
    dat_d = (push && wp_q == rp_d) ? wr.data : mem_q[rp_d];
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
      rdy_q <= 1'b0;
      vld_q <= 1'b0;
      dat_q <= '0;
    end else begin
      wp_q  <= wp_d;
      rp_q  <= rp_d;
      cnt_q <= cnt_d;
      rdy_q <= rdy_d;
      vld_q <= vld_d;
      dat_q <= dat_d;
    end
  end

  // Storage needs no reset; flags guard every read
  always_ff @(posedge clk) begin
    if (push) mem_q[wp_q] <= wr.data;
  end

  assign wr.ready = rdy_q;
  assign rd.valid = vld_q;
  assign rd.data  = dat_q;
  assign level    = cnt_q;
endmodule : iifm_fifo

// ==== verilog/iifm_halfband.sv ====
`timescale 1ns/1ps
module iifm_halfband (
  input  wire logic               clk,
  input  wire logic               rst_n,
  input  wire logic               in_en,
  input  wire logic               out_en,
  input  wire logic signed [15:0] din,
  output logic signed [15:0]      dout
);
  logic signed [15:0] x_q [4];
  logic signed [15:0] x_d [4];
  logic signed [15:0] y_q, y_d;
  logic signed [21:0] acc;

  // ----------------------------------------------------------------
  // Seven-tap half-band, taps -1 0 9 16 9 0 -1 over 16, polyphase
  // ----------------------------------------------------------------
  // Even phase repeats a centre sample, odd phase is the midpoint
  always_comb begin
    x_d = x_q;
    y_d = y_q;
    acc = 22'sh000009 * (22'(x_q[1]) + 22'(x_q[2])) - (22'(x_q[0]) + 22'(x_q[3]));
    if (in_en) begin
      x_d = '{din, x_q[0], x_q[1], x_q[2]};
      y_d = x_q[1];
    end else if (out_en) begin
      y_d = iifm_pkg::sat16(acc >>> 4); // Overshoot clips, never wraps
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      x_q <= '{default: '0};
      y_q <= '0;
    end else begin
      x_q <= x_d;
      y_q <= y_d;
    end
  end

  assign dout = y_q;
endmodule : iifm_halfband

// ==== verilog/iifm_top.sv ====
// Our own choices: the Wishbone interface to the registers and the register offsets.
`timescale 1ns/1ps
// Operation
// - I and Q each own three cascaded half-band stages, up to eight-fold.
// - Modulation field zero bypasses both mixers; interpolated samples pass unmixed.
// - Without modulation the block interpolates by one, two, four or eight.
// - Nonzero modulation field runs mixers at fs/2, fs/4 or fs/8.
// - Mix-type bit set selects real mixing per channel.
// - Real mixing multiplies each channel by the carrier, no I/Q cross terms.
// - Mix-type bit clear selects complex modulation.
// - Complex mode couples channels, I real and Q imaginary.
// - Complex rotation sign selects upper or lower image rejection.
// - Carrier steps at the output sample rate, not the input rate.
// - Carrier cosine and sine are the complex multiply coefficients.
// - Opposite sideband negates the sine terms only.
// - Input words are two's complement or offset binary per a control bit.
module iifm_top (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        in_valid,
  output logic             in_ready,
  input  wire logic [13:0] in_i,
  input  wire logic [13:0] in_q,
  output logic [13:0]      dac_i,
  output logic [13:0]      dac_q
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic               ack_q, ack_d;
  logic [31:0]        rdat_q, rdat_d;
  logic [7:0]         ctrl1_q, ctrl1_d;
  logic [7:0]         ctrl2_q, ctrl2_d;
  logic               req, wr_en, uclr;
  logic [1:0]         n_sel, mod;
  logic               real_mix, side, fmt, run;
  logic [2:0]         imask, step;
  logic               take;
  logic [2:0]         cnt_q, cnt_d;
  logic [2:0]         ph_q, ph_d;
  logic               under_q, under_d;
  logic signed [15:0] samp_i_q, samp_i_d;
  logic signed [15:0] samp_q_q, samp_q_d;
  logic [5:0]         level;
  logic signed [15:0] sd_i [4];
  logic signed [15:0] sd_q [4];
  logic signed [15:0] so_i [3];
  logic signed [15:0] so_q [3];
  logic [2:0]         act, s_in_en, s_out_en;
  logic signed [15:0] ci, cq, cosv, sinv;
  logic signed [19:0] ci20, cq20, mi, mq;
  logic signed [32:0] acc_i, acc_q;
  logic [13:0]        dac_i_q, dac_i_d;
  logic [13:0]        dac_q_q, dac_q_d;

  iifm_stream_if #(.W(iifm_pkg::FIFO_W)) push_if ();
  iifm_stream_if #(.W(iifm_pkg::FIFO_W)) pop_if ();

  // ----------------------------------------------------------------
  // Wishbone slave
  // ----------------------------------------------------------------
  // Ack one cycle after the request; writes land at the ack edge
  assign req   = wb_cyc_i && wb_stb_i;
  assign wr_en = req && wb_we_i && ack_q;

  always_comb begin
    ack_d   = req && !ack_q;
    rdat_d  = 32'h0;
    ctrl1_d = ctrl1_q;
    ctrl2_d = ctrl2_q;
    uclr    = 1'b0;
    if (req && !ack_q && !wb_we_i) begin
      case (wb_adr_i)
        iifm_pkg::CTRL1_ADR: rdat_d[7:0] = ctrl1_q;
        iifm_pkg::CTRL2_ADR: rdat_d[7:0] = ctrl2_q;
        iifm_pkg::STAT_ADR: begin
          rdat_d[iifm_pkg::STAT_LVL_LSB +: 6] = level;
          rdat_d[iifm_pkg::STAT_UND_BIT]      = under_q;
          rdat_d[iifm_pkg::STAT_RUN_BIT]      = run;
        end
        default: rdat_d = 32'h0; // Unmapped reads answer zero
      endcase
    end
    if (wr_en) begin
      case (wb_adr_i)
        iifm_pkg::CTRL1_ADR: if (wb_sel_i[0]) ctrl1_d = wb_dat_i[7:0];
        iifm_pkg::CTRL2_ADR: if (wb_sel_i[0]) ctrl2_d = wb_dat_i[7:0];
        iifm_pkg::STAT_ADR: begin
          uclr = wb_sel_i[1] && wb_dat_i[iifm_pkg::STAT_UND_BIT];
        end
        default: uclr = 1'b0; // Unmapped writes are dropped
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ack_q   <= 1'b0;
      rdat_q  <= 32'h0;
      ctrl1_q <= iifm_pkg::CTRL1_RST;
      ctrl2_q <= iifm_pkg::CTRL2_RST;
    end else begin
      ack_q   <= ack_d;
      rdat_q  <= rdat_d;
      ctrl1_q <= ctrl1_d;
      ctrl2_q <= ctrl2_d;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;

  // ----------------------------------------------------------------
  // Control fields
  // ----------------------------------------------------------------
  assign n_sel    = ctrl1_q[iifm_pkg::INTERP_LSB +: 2];
  assign mod      = ctrl1_q[iifm_pkg::MOD_LSB +: 2];
  assign real_mix = ctrl1_q[iifm_pkg::REAL_BIT];
  assign side     = ctrl1_q[iifm_pkg::SIDE_BIT];
  assign fmt      = ctrl2_q[iifm_pkg::FMT_BIT];
  assign run      = ctrl2_q[iifm_pkg::RUN_BIT];

  // ----------------------------------------------------------------
  // Input buffer
  // ----------------------------------------------------------------
  // Full buffer drops in_ready, so the source is stalled, not lost
  assign push_if.valid = in_valid;
  assign push_if.data  = {in_i, in_q};
  assign in_ready      = push_if.ready;
  assign pop_if.ready  = take;

  iifm_fifo u_fifo (
    .clk   (clk),
    .rst_n (rst_n),
    .wr    (push_if),
    .rd    (pop_if),
    .level (level)
  );

  // ----------------------------------------------------------------
  // Rate divider, carrier phase and sample intake
  // ----------------------------------------------------------------
  // One sample per 2^n output ticks; the clock itself is fs
  assign imask = ~(3'h7 << n_sel);
  assign take  = run && ((cnt_q & imask) == 3'h0);

  // Phase step in eighths of a turn per output tick
  always_comb begin
    case (mod)
      iifm_pkg::MOD_FS2: step = 3'h4;
      iifm_pkg::MOD_FS4: step = 3'h2;
      iifm_pkg::MOD_FS8: step = 3'h1;
      default:           step = 3'h0;
    endcase
  end

  // Underflow feeds zeros; a new underflow beats a same-cycle clear
  always_comb begin
    cnt_d    = run ? cnt_q + 3'h1 : 3'h0;
    ph_d     = run ? ph_q + step : 3'h0;
    samp_i_d = samp_i_q;
    samp_q_d = samp_q_q;
    under_d  = under_q && !uclr;
    if (take) begin
      if (pop_if.valid) begin
        samp_i_d = iifm_pkg::to_int(pop_if.data[27:14], fmt);
        samp_q_d = iifm_pkg::to_int(pop_if.data[13:0], fmt);
      end else begin
        samp_i_d = 16'sh0000;
        samp_q_d = 16'sh0000;
        under_d  = 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt_q    <= 3'h0;
      ph_q     <= 3'h0;
      under_q  <= 1'b0;
      samp_i_q <= 16'sh0000;
      samp_q_q <= 16'sh0000;
    end else begin
      cnt_q    <= cnt_d;
      ph_q     <= ph_d;
      under_q  <= under_d;
      samp_i_q <= samp_i_d;
      samp_q_q <= samp_q_d;
    end
  end

  // ----------------------------------------------------------------
  // Interpolation chains
  // ----------------------------------------------------------------
  // Last n stages run; earlier stages are skipped by the mux
  assign sd_i[0] = samp_i_q;
  assign sd_q[0] = samp_q_q;

  for (genvar s = 0; s < 3; s++) begin : g_stage
    assign act[s]      = (s + 32'(n_sel)) >= 3;
    assign s_in_en[s]  = run && ((cnt_q & (3'h7 >> s)) == 3'h0);
    assign s_out_en[s] = run && ((cnt_q & (3'h3 >> s)) == 3'h0);
    iifm_halfband u_hb_i (
      .clk    (clk),
      .rst_n  (rst_n),
      .in_en  (s_in_en[s]),
      .out_en (s_out_en[s]),
      .din    (sd_i[s]),
      .dout   (so_i[s])
    );
    iifm_halfband u_hb_q (
      .clk    (clk),
      .rst_n  (rst_n),
      .in_en  (s_in_en[s]),
      .out_en (s_out_en[s]),
      .din    (sd_q[s]),
      .dout   (so_q[s])
    );
    assign sd_i[s+1] = act[s] ? so_i[s] : sd_i[s];
    assign sd_q[s+1] = act[s] ? so_q[s] : sd_q[s];
  end

  assign ci   = sd_i[3];
  assign cq   = sd_q[3];
  assign ci20 = 20'(ci);
  assign cq20 = 20'(cq);

  // ----------------------------------------------------------------
  // Modulator
  // ----------------------------------------------------------------
  // Sine is cosine two eighths late; eighth-turn taps are rounded
  always_comb begin
    cosv  = iifm_pkg::cos_q14(ph_q);
    sinv  = iifm_pkg::cos_q14(ph_q - 3'h2);
    acc_i = 33'sh0;
    acc_q = 33'sh0;
    if (!real_mix && side) begin
      sinv = -sinv;
    end
    if (real_mix) begin
      acc_i = 33'(ci) * 33'(cosv);
      acc_q = 33'(cq) * 33'(cosv);
    end else begin
      acc_i = 33'(ci) * 33'(cosv) - 33'(cq) * 33'(sinv);
      acc_q = 33'(ci) * 33'(sinv) + 33'(cq) * 33'(cosv);
    end
    if (mod == iifm_pkg::MOD_OFF) begin
      mi = ci20;
      mq = cq20;
    end else begin
      mi = {acc_i[32], acc_i[32:14]};
      mq = {acc_q[32], acc_q[32:14]};
    end
    dac_i_d = run ? iifm_pkg::sat14(mi) : 14'h0;
    dac_q_d = run ? iifm_pkg::sat14(mq) : 14'h0;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      dac_i_q <= 14'h0;
      dac_q_q <= 14'h0;
    end else begin
      dac_i_q <= dac_i_d;
      dac_q_q <= dac_q_d;
    end
  end

  assign dac_i = dac_i_q;
  assign dac_q = dac_q_q;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  chk_mod_bypass: assert property (
    run && mod == iifm_pkg::MOD_OFF |=> dac_i_q == iifm_pkg::sat14($past(ci20))
      && dac_q_q == iifm_pkg::sat14($past(cq20)))
    else $error("bypass output differs from interpolated sample");

  chk_take_rate: assert property (
    take && n_sel == 2'h3 |=> (!take || n_sel != 2'h3 || $changed(n_sel) || $rose(run)) [*7])
    else $error("eight-fold intake came early");

  chk_fs2_step: assert property (
    run && mod == iifm_pkg::MOD_FS2 |=> ph_q == $past(ph_q) + 3'h4)
    else $error("fs/2 carrier phase did not step");

  chk_fs8_step: assert property (
    run && mod == iifm_pkg::MOD_FS8 |=> ph_q == $past(ph_q) + 3'h1)
    else $error("fs/8 carrier phase did not step");

  chk_real_invert: assert property (
    run && real_mix && mod == iifm_pkg::MOD_FS2 && ph_q == 3'h4
      |=> dac_q_q == iifm_pkg::sat14(-$past(cq20)) && dac_i_q == iifm_pkg::sat14(-$past(ci20)))
    else $error("real mix at cos -1 did not invert");

  chk_real_isolate: assert property (
    run && real_mix && mod != iifm_pkg::MOD_OFF && cq == 16'sh0000 |=> dac_q_q == 14'h0)
    else $error("real mix leaked I into Q");

  chk_cplx_rotate: assert property (
    run && !real_mix && !side && mod == iifm_pkg::MOD_FS4 && ph_q == 3'h2
      |=> dac_i_q == iifm_pkg::sat14(-$past(cq20)) && dac_q_q == iifm_pkg::sat14($past(ci20)))
    else $error("positive rotation wrong at quarter turn");

  chk_cplx_sideband: assert property (
    run && !real_mix && side && mod == iifm_pkg::MOD_FS4 && ph_q == 3'h2
      |=> dac_i_q == iifm_pkg::sat14($past(cq20)) && dac_q_q == iifm_pkg::sat14(-$past(ci20)))
    else $error("negative rotation wrong at quarter turn");

  chk_cplx_cosine: assert property (
    run && !real_mix && mod == iifm_pkg::MOD_FS8 && ph_q == 3'h0
      |=> dac_i_q == iifm_pkg::sat14($past(ci20)) && dac_q_q == iifm_pkg::sat14($past(cq20)))
    else $error("complex mix at zero phase not identity");

  chk_fmt_offset: assert property (
    take && pop_if.valid && fmt |=> samp_i_q[13] == !$past(pop_if.data[27]))
    else $error("offset binary sign not flipped");

  chk_underflow_set: assert property (
    take && !pop_if.valid |=> under_q && samp_i_q == 16'sh0000)
    else $error("underflow not flagged");

  chk_ack_pulse: assert property (
    req && !ack_q |=> ack_q ##1 !ack_q)
    else $error("ack not a single cycle");

endmodule : iifm_top

// ==== tb/iifm_src_model.sv ====
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Baseband source model
// ----------------------------------------------------------------
module iifm_src_model (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        enable,
  input  wire logic        slow,
  input  wire logic        ofs,
  input  wire logic [13:0] val_i,
  input  wire logic [13:0] val_q,
  input  wire logic        in_ready,
  output logic             in_valid,
  output logic [13:0]      in_i,
  output logic [13:0]      in_q,
  output logic [7:0]       taken
);
  logic gap_q;

  // Hold each pair until taken; idle data toggles so stale words never look valid
  always @(posedge clk) begin
    if (!rst_n) begin
      in_valid <= 1'b0;
      in_i     <= 14'h1555;
      in_q     <= 14'h2aaa;
      taken    <= 8'h00;
      gap_q    <= 1'b0;
    end else begin
      if (in_valid && in_ready) begin
        taken <= taken + 8'h01;
      end
      if (!in_valid || in_ready) begin
        gap_q    <= slow & ~gap_q;
        in_valid <= enable & ~(slow & ~gap_q);
        if (enable && !(slow && !gap_q)) begin
          in_i <= {val_i[13] ^ ofs, val_i[12:0]};
          in_q <= {val_q[13] ^ ofs, val_q[12:0]};
        end else begin
          in_i <= ~in_i;
          in_q <= ~in_q;
        end
      end
    end
  end
endmodule : iifm_src_model

// ==== tb/testbench.sv ====
`timescale 1ns/1ps
module testbench;
  logic        clk;
  logic        rst_n;
  logic        wb_cyc;
  logic        wb_stb;
  logic        wb_we;
  logic [7:0]  wb_adr;
  logic [3:0]  wb_sel;
  logic [31:0] wb_dat;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic        in_valid;
  logic        in_ready;
  logic [13:0] in_i;
  logic [13:0] in_q;
  logic [13:0] dac_i;
  logic [13:0] dac_q;
  logic        src_en;
  logic        src_slow;
  logic        ofs;
  logic [13:0] val_i;
  logic [13:0] val_q;
  logic [7:0]  taken;
  logic [31:0] rdata;
  logic [31:0] r;
  logic [13:0] s_i[0:15];
  logic [13:0] s_q[0:15];
  logic        hit;
  int          errors;
  int          check_count;
  int          h;
  integer      seed;

  // ----------------------------------------------------------------
  // Instances
  // ----------------------------------------------------------------
  iifm_top uut (
    .clk      (clk),
    .rst_n    (rst_n),
    .wb_cyc_i (wb_cyc),
    .wb_stb_i (wb_stb),
    .wb_we_i  (wb_we),
    .wb_adr_i (wb_adr),
    .wb_sel_i (wb_sel),
    .wb_dat_i (wb_dat),
    .wb_dat_o (wb_dat_o),
    .wb_ack_o (wb_ack_o),
    .in_valid (in_valid),
    .in_ready (in_ready),
    .in_i     (in_i),
    .in_q     (in_q),
    .dac_i    (dac_i),
    .dac_q    (dac_q)
  );

  iifm_src_model src (
    .clk      (clk),
    .rst_n    (rst_n),
    .enable   (src_en),
    .slow     (src_slow),
    .ofs      (ofs),
    .val_i    (val_i),
    .val_q    (val_q),
    .in_ready (in_ready),
    .in_valid (in_valid),
    .in_i     (in_i),
    .in_q     (in_q),
    .taken    (taken)
  );

  // 20 MHz clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Within one LSB, since the fs/8 taps are rounded
  function automatic logic near(input logic [13:0] a, input logic [13:0] b);
    logic [13:0] d;
    d = a - b;
    return (d == 14'h0000) || (d == 14'h0001) || (d == 14'h3fff);
  endfunction : near

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic give_verdict();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : give_verdict

  // Classic cycle; ack sampled at a rising edge, request released right after it
  task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [31:0] dat, input logic [3:0] sel);
    int n;
    n = 0;
    @(posedge clk);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we  <= we;
    wb_adr <= adr;
    wb_dat <= dat;
    wb_sel <= sel;
    do begin
      @(posedge clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    if (wb_ack_o !== 1'b1) begin
      errors++;
      give_verdict();
    end
    rdata = wb_dat_o;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we  <= 1'b0;
  endtask : wb_xfer

  // Let filters and FIFO settle, then capture sixteen output samples
  task automatic grab();
    repeat (400) @(posedge clk);
    for (int k = 0; k < 16; k++) begin
      @(negedge clk);
      s_i[k] = dac_i;
      s_q[k] = dac_q;
    end
  endtask : grab

  task automatic new_val(input logic with_q);
    r = $random(seed);
    val_i <= {{2{r[13]}}, ~r[13], r[10:0]};
    val_q <= with_q ? {{2{r[29]}}, ~r[29], r[26:16]} : 14'h0000;
  endtask : new_val

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    seed = 32'h537b2925;
    {rst_n, wb_cyc, wb_stb, wb_we, wb_adr, wb_sel, wb_dat} = '0;
    {src_en, src_slow, ofs, val_i, val_q, errors, check_count} = '0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    wb_xfer(1'b0, iifm_pkg::CTRL1_ADR, 32'h0, 4'hf);
    check("ctrl1 reset", rdata, 32'h0);
    wb_xfer(1'b0, iifm_pkg::CTRL2_ADR, 32'h0, 4'hf);
    check("ctrl2 reset", rdata, 32'h0);
    wb_xfer(1'b0, 8'h40, 32'h0, 4'hf);
    check("unmapped", rdata, 32'h0);
    wb_xfer(1'b1, iifm_pkg::CTRL1_ADR, 32'h3f, 4'h0);
    wb_xfer(1'b0, iifm_pkg::CTRL1_ADR, 32'h0, 4'hf);
    check("ctrl1 no sel", rdata, 32'h0);
    // Fill the buffer while stopped: refuses at 32 words
    new_val(1'b1);
    src_en <= 1'b1;
    repeat (60) @(posedge clk);
    check("in_ready full", in_ready, 1'b0);
    check("taken", taken, 8'd32);
    wb_xfer(1'b0, iifm_pkg::STAT_ADR, 32'h0, 4'hf);
    check("level", rdata, 32'h20);
    check("dac stopped", dac_i, 14'h0000);
    // DC passes unmixed at every rate
    for (int c = 0; c < 4; c++) begin
      src_slow <= c[1];
      wb_xfer(1'b1, iifm_pkg::CTRL1_ADR, c, 4'h1);
      wb_xfer(1'b1, iifm_pkg::CTRL2_ADR, 32'h1, 4'h1);
      if (c == 3) begin
        ofs <= 1'b1;
        wb_xfer(1'b1, iifm_pkg::CTRL2_ADR, 32'h81, 4'h1);
      end
      grab();
      for (int k = 0; k < 8; k++) begin
        check("dc i", s_i[k], val_i);
        check("dc q", s_q[k], val_q);
      end
      new_val(1'b1);
    end
    ofs <= 1'b0;
    wb_xfer(1'b1, iifm_pkg::CTRL2_ADR, 32'h1, 4'h1);
    // Real mixing, each code, input at one eighth of fs
    new_val(1'b0);
    for (int m = 1; m < 4; m++) begin
      wb_xfer(1'b1, iifm_pkg::CTRL1_ADR, (m << 4) | 7, 4'h1);
      grab();
      h = 1 << (m - 1);
      hit = 1'b0;
      for (int k = 0; k < 8; k++) begin
        check("half period", near(s_i[k + h], 14'h0 - s_i[k]), 1'b1);
        check("no cross", s_q[k], 14'h0000);
        hit = hit | near(s_i[k], val_i);
      end
      check("real peak", hit, 1'b1);
    end
    // Complex fs/4 both rotations, then fs/8 positive; quarter turn lies h ticks on
    for (int sd = 0; sd < 3; sd++) begin
      wb_xfer(1'b1, iifm_pkg::CTRL1_ADR, (sd == 2) ? 32'h33 : 32'h23 | (sd << 3), 4'h1);
      grab();
      h = (sd == 2) ? 2 : 1;
      hit = 1'b0;
      for (int k = 0; k < 8; k++) begin
        if (!hit && near(s_i[k], val_i)) begin
          hit = 1'b1;
          check("cplx q0", near(s_q[k], 14'h0000), 1'b1);
          check("cplx side", near(s_q[k + h], sd == 1 ? 14'h0 - val_i : val_i), 1'b1);
        end
      end
      check("cplx coupled", hit, 1'b1);
    end
    // Starve the buffer: zeros out, sticky underflow, then clear
    wb_xfer(1'b1, iifm_pkg::CTRL1_ADR, 32'h0, 4'h1);
    src_en <= 1'b0;
    grab();
    check("starved", s_i[0], 14'h0000);
    wb_xfer(1'b0, iifm_pkg::STAT_ADR, 32'h0, 4'hf);
    check("underflow", rdata, 32'h300);
    wb_xfer(1'b1, iifm_pkg::CTRL2_ADR, 32'h0, 4'h1);
    wb_xfer(1'b1, iifm_pkg::STAT_ADR, 32'h100, 4'h2);
    wb_xfer(1'b0, iifm_pkg::STAT_ADR, 32'h0, 4'hf);
    check("cleared", rdata, 32'h0);
    give_verdict();
  end
endmodule : testbench
